// ===== common/flash_reg_pkg.sv
// package: codes, layout, timing and carriers of the register command block
`default_nettype none
package flash_reg_pkg;

   // command codes, sent most significant bit first
   localparam logic [7:0] CMD_LATCH_SET  = 8'h06;
   localparam logic [7:0] CMD_LATCH_CLR  = 8'h04;
   localparam logic [7:0] CMD_STATUS_RD  = 8'h05;
   localparam logic [7:0] CMD_FLAG_RD    = 8'h70;
   localparam logic [7:0] CMD_NVCFG_RD   = 8'hb5;
   localparam logic [7:0] CMD_VCFG_RD    = 8'h85;
   localparam logic [7:0] CMD_STATUS_WR  = 8'h01;
   localparam logic [7:0] CMD_NVCFG_WR   = 8'hb1;
   localparam logic [7:0] CMD_VCFG_WR    = 8'h81;
   localparam logic [7:0] CMD_FLAG_CLR   = 8'h50;

   // frame counting
   localparam logic [2:0] LAST_BIT       = 3'h7;
   localparam logic [3:0] BYTES_MAX      = 4'hf;
   localparam logic [3:0] ADDR_BYTES_3   = 4'h3;
   localparam logic [3:0] ADDR_BYTES_4   = 4'h4;
   localparam logic [3:0] STATUS_WR_LEN  = 4'h2;
   localparam logic [3:0] CFG_DATA_LEN   = 4'h2;

   // status byte: bits 1:0 are live, bits 7:2 are software protection
   localparam int SR_BUSY       = 0;
   localparam int SR_WEL        = 1;
   localparam int SR_LOCK       = 5;
   // flag status byte
   localparam int FSR_READY     = 7;
   localparam int FSR_ERASE_ERR = 5;
   localparam int FSR_PROG_ERR  = 4;
   localparam int FSR_PROT_ERR  = 1;

   // reset values
   localparam logic [5:0] STATUS_PROT_RST = 6'h00;
   localparam logic [7:0] NVCFG_RST       = 8'hff;
   localparam logic [7:0] VCFG_RST        = 8'hff;
   localparam logic [7:0] CFG_RSVD_MASK   = 8'h00;

   // self-timed write durations
   localparam int unsigned STATUS_WRITE_TIME_NS = 1000000;
   localparam int unsigned NVCFG_WRITE_TIME_NS  = 1000000;
   localparam int unsigned CLK_PERIOD_NS        = 4;

   // register view handed to the link domain
   typedef struct packed {
      logic       octal;
      logic       four_byte;
      logic [7:0] status;
      logic [7:0] flag;
      logic [7:0] nvcfg;
      logic [7:0] vcfg;
   } link_view_type;

   // frame summary handed to the core domain once select is high
   typedef struct packed {
      logic       idle;
      logic       partial;
      logic [3:0] bytes;
      logic [7:0] cmd;
      logic [7:0] last;
   } frame_type;

   function automatic logic [3:0] addr_bytes(input logic four);
      return four ? ADDR_BYTES_4 : ADDR_BYTES_3;
   endfunction : addr_bytes

   function automatic logic is_cfg_read(input logic [7:0] cmd);
      return (cmd == CMD_NVCFG_RD) || (cmd == CMD_VCFG_RD);
   endfunction : is_cfg_read

   function automatic logic is_reg_read(input logic [7:0] cmd);
      return (cmd == CMD_STATUS_RD) || (cmd == CMD_FLAG_RD) || is_cfg_read(cmd);
   endfunction : is_reg_read

endpackage : flash_reg_pkg
`default_nettype wire

// ===== verilog/pin_sync3.sv
// three-stage pin synchroniser, a change passes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
   import flash_reg_pkg::*;
#(
   parameter int               WIDTH     = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] stage3_ff;
   logic [WIDTH-1:0] held_ff;

   // follow once stages two and three agree, so a glitch never passes
   wire logic [WIDTH-1:0] nxt_held = (stage2_ff & stage3_ff) | (held_ff & (stage2_ff | stage3_ff));

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_ff   <= RESET_VAL;
         stage2_ff <= RESET_VAL;
         stage3_ff <= RESET_VAL;
         held_ff   <= RESET_VAL;
      end else begin
         meta_ff   <= async_i;
         stage2_ff <= meta_ff;
         stage3_ff <= stage2_ff;
         held_ff   <= nxt_held;
      end
   end

   assign sync_o = held_ff;

endmodule : pin_sync3
`default_nettype wire

// ===== verilog/flash_reg_cmd.sv
// register command interpreter: latch, status, flag and config registers
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: host holds select low for the eight latch code bits, then raises it
// RL2: command code on data line zero (extended) or all eight lines (octal)
// RL3: latch command with extra clocks before select rises is dropped, flags untouched
// RL4: code 06h sets the write enable latch, needed before any write
// RL5: code 04h clears the latch unless a protection error is pending
// RL6: code 50h clears erase, program, protection errors and then the latch; the code clears the latch only if a protection error was pending
// RL7: extended reads take line zero, answer on line one; octal uses all; select ends
// RL8: status 05h and flag 70h reads accepted anytime, repeat continuously
// RL9: config reads B5h/85h repeat the same byte, reserved fields read one
// RL10: host sends latch set before every register write
// RL11: write executes only if select rises right after last data byte
// RL12: status and nonvolatile config writes take their own self-timed durations
// RL13: status write updates bits 7 to 2 only
// RL14: protection bits with write protect pin give hardware write protection
// RL15: busy reads one during a timed write; at end busy and latch clear
// RL16: volatile config write is immediate and keeps reserved bits
// RL17: config reads and writes carry four address bytes in four-byte mode
// RL18: address bits are sampled on rising serial clock
// RL19: code bits go most significant first, sampled on rising serial clock
module flash_reg_cmd
   import flash_reg_pkg::*;
#(
   parameter int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS,
   parameter int unsigned NVCFG_WRITE_CYCLES  = NVCFG_WRITE_TIME_NS / CLK_PERIOD_NS,
   parameter logic [7:0]  NVCFG_RSVD_MASK     = CFG_RSVD_MASK,
   parameter logic [7:0]  VCFG_RSVD_MASK      = CFG_RSVD_MASK
) (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       sclk_i,
   input  wire logic       chip_select_n_i,
   input  wire logic [7:0] dq_i,
   output logic      [7:0] dq_o,
   output logic      [7:0] dq_oe_o,
   input  wire logic       write_protect_n_i,
   input  wire logic       octal_mode_i,
   input  wire logic       four_byte_mode_i,
   input  wire logic       array_busy_i,
   input  wire logic       program_fail_i,
   input  wire logic       erase_fail_i,
   input  wire logic       protect_fail_i,
   output logic            wel_o,
   output logic            busy_o,
   output logic      [7:0] status_o,
   output logic      [7:0] flag_status_o,
   output logic      [7:0] nvcfg_o,
   output logic      [7:0] vcfg_o
);

   ////////////////////////////////
   // declarations

   // link side
   link_view_type view_meta_ff;
   link_view_type view_ff;
   logic          fresh_ff;
   logic [7:0]    shift_ff;
   logic [2:0]    bits_ff;
   logic [3:0]    bytes_ff;
   logic [7:0]    cmd_ff;
   logic [7:0]    last_ff;
   logic          rd_active_ff;
   logic          drive_ff;
   logic [7:0]    out_ff;
   logic [2:0]    out_bits_ff;
   logic          frame_tog_ff;

   // core side
   logic [1:0]    pin_s;
   logic          cs_prev_ff;
   logic          tog_seen_ff;
   logic          wel_ff;
   logic [5:0]    status_ff;
   logic [7:0]    nvcfg_ff;
   logic [7:0]    vcfg_ff;
   logic          erase_err_ff;
   logic          prog_err_ff;
   logic          prot_err_ff;
   logic          wr_busy_ff;
   logic          wr_nv_ff;
   logic [31:0]   wr_cnt_ff;
   logic [7:0]    pend_ff;
   logic [7:0]    status_byte;
   logic [7:0]    flag_byte;
   link_view_type core_view;
   frame_type     frame;

   ////////////////////////////////
   // link domain: register view crossing
   // the view is a slow-changing level set; each bit crosses on two flops
   always_ff @(posedge sclk_i) begin
      view_meta_ff <= core_view;
      view_ff      <= view_meta_ff;
   end

   ////////////////////////////////
   // link domain: frame capture on rising serial clock
   // select high marks the next frame as new
   always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         fresh_ff <= 1'b1;
      end else begin
         fresh_ff <= 1'b0;
      end
   end

   // flips at each frame's first edge, so the core tells a clocked frame from an idle one
   always_ff @(posedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         frame_tog_ff <= 1'b0;
      end else if (fresh_ff) begin
         frame_tog_ff <= ~frame_tog_ff;
      end
   end

   // mode is a static level; the crossed view would lag two serial clock edges behind it
   wire logic       oct_l     = octal_mode_i;
   wire logic [3:0] alen_l    = addr_bytes(view_ff.four_byte); // RL17
   wire logic [2:0] bit_base  = fresh_ff ? 3'h0 : bits_ff;
   wire logic [3:0] byte_base = fresh_ff ? 4'h0 : bytes_ff;

   // extended: one bit on line zero, msb first; octal: whole byte each edge
   wire logic [7:0] shift_nxt = oct_l ? dq_i : {shift_ff[6:0], dq_i[0]}; // RL2 RL19
   wire logic       byte_done = oct_l | (bit_base == LAST_BIT);
   wire logic [7:0] cmd_now   = (byte_base == 4'h0) ? shift_nxt : cmd_ff;

   // header is the code, plus the address for config reads
   wire logic [3:0] hdr_len   = is_cfg_read(cmd_now) ? alen_l + 4'h1 : 4'h1; // RL17
   wire logic       rd_start  = byte_done & is_reg_read(cmd_now)
                              & ((byte_base + 4'h1) == hdr_len);
   wire logic [3:0] nxt_bytes = (byte_done && byte_base != BYTES_MAX) ? byte_base + 4'h1
                                                                      : byte_base;
   wire logic [2:0] nxt_bits  = oct_l ? 3'h0 : bit_base + 3'h1;

   // every bit is taken on the rising edge
   always_ff @(posedge sclk_i) begin
      shift_ff <= shift_nxt; // RL18 RL19
      bits_ff  <= nxt_bits;
      bytes_ff <= nxt_bytes;
   end

   // code and last whole byte, judged by the core at frame end
   always_ff @(posedge sclk_i) begin
      if (byte_done && byte_base == 4'h0) begin
         cmd_ff <= shift_nxt;
      end
      if (byte_done) begin
         last_ff <= shift_nxt;
      end
   end

   // read phase opens after the header and closes only with select
   always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         rd_active_ff <= 1'b0; // RL7
      end else if (rd_start) begin
         rd_active_ff <= 1'b1; // RL8
      end
   end

   ////////////////////////////////
   // link domain: answer on falling serial clock

   wire logic [7:0] out_sel = (cmd_ff == CMD_STATUS_RD) ? view_ff.status :
                              (cmd_ff == CMD_FLAG_RD)   ? view_ff.flag   :
                              (cmd_ff == CMD_NVCFG_RD)  ? view_ff.nvcfg  :
                                                          view_ff.vcfg;

   // reload each byte so status reads track live busy
   wire logic       reload  = oct_l | (out_bits_ff == 3'h0);

   always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         drive_ff    <= 1'b0; // RL7
         out_ff      <= 8'h00;
         out_bits_ff <= 3'h0;
      end else if (rd_active_ff) begin
         drive_ff    <= 1'b1;
         out_ff      <= reload ? out_sel : {out_ff[6:0], 1'b0}; // RL8 RL9
         out_bits_ff <= out_bits_ff + 3'h1;
      end
   end

   // extended answers on line one only, octal on all lines
   assign dq_o    = oct_l ? out_ff : {6'h00, out_ff[7], 1'b0}; // RL7
   assign dq_oe_o = !drive_ff ? 8'h00 : (oct_l ? 8'hff : 8'h02); // RL7

   ////////////////////////////////
   // core domain: select and write-protect pins
   pin_sync3 #(
      .WIDTH     (2),
      .RESET_VAL (2'b11)
   ) u_pin_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({write_protect_n_i, chip_select_n_i}),
      .sync_o  (pin_s)
   );

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cs_prev_ff  <= 1'b1;
         tog_seen_ff <= 1'b0;
      end else begin
         cs_prev_ff <= pin_s[0];
         if (pin_s[0] && !cs_prev_ff) begin
            tog_seen_ff <= frame_tog_ff;
         end
      end
   end

   // frame summary is stable here: the clock has stopped since select rose
   assign frame = '{idle:    (frame_tog_ff == tog_seen_ff),
                    partial: (bits_ff != 3'h0),
                    bytes:   bytes_ff,
                    cmd:     cmd_ff,
                    last:    last_ff};

   ////////////////////////////////
   // core domain: command decode at frame end

   wire logic       frame_end = pin_s[0] & ~cs_prev_ff;
   // a frame is whole only when it stops exactly on a byte boundary
   wire logic       whole     = frame_end & ~frame.idle & ~frame.partial; // RL11
   wire logic [3:0] alen_c    = addr_bytes(four_byte_mode_i); // RL17
   wire logic [3:0] cfg_len   = alen_c + CFG_DATA_LEN; // RL17
   wire logic       one_byte  = (frame.bytes == 4'h1);
   wire logic       can_write = wel_ff & ~wr_busy_ff; // RL10

   // latch codes count only when select rises right after the eighth bit
   wire logic do_set   = whole & one_byte & (frame.cmd == CMD_LATCH_SET); // RL1 RL3 RL4
   wire logic do_clr   = whole & one_byte & (frame.cmd == CMD_LATCH_CLR); // RL1 RL3 RL5
   // flag clear may be cut short at any point after its code
   wire logic do_fclr  = frame_end & ~frame.idle & (frame.bytes != 4'h0)
                       & (frame.cmd == CMD_FLAG_CLR); // RL6

   wire logic sw_frame = whole & can_write & (frame.bytes == STATUS_WR_LEN)
                       & (frame.cmd == CMD_STATUS_WR); // RL11
   // lock bit plus a low protect pin refuses status writes
   wire logic hw_lock  = status_ff[SR_LOCK] & ~pin_s[1]; // RL14
   wire logic do_sw    = sw_frame & ~hw_lock; // RL14
   wire logic sw_block = sw_frame & hw_lock; // RL14
   wire logic do_nw    = whole & can_write & (frame.bytes == cfg_len)
                       & (frame.cmd == CMD_NVCFG_WR); // RL11 RL17
   wire logic do_vw    = whole & can_write & (frame.bytes == cfg_len)
                       & (frame.cmd == CMD_VCFG_WR); // RL11 RL17

   wire logic wr_done  = wr_busy_ff & (wr_cnt_ff == 32'h0);

   ////////////////////////////////
   // core domain: self-timed register writes

   wire logic [31:0] wr_load = do_nw ? 32'(NVCFG_WRITE_CYCLES - 1)
                                     : 32'(STATUS_WRITE_CYCLES - 1);

   // new value lands only when the write time runs out
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_busy_ff <= 1'b0;
         wr_nv_ff   <= 1'b0;
         wr_cnt_ff  <= 32'h0;
         pend_ff    <= 8'h00;
      end else if (do_sw || do_nw) begin
         wr_busy_ff <= 1'b1; // RL15
         wr_nv_ff   <= do_nw;
         wr_cnt_ff  <= wr_load; // RL12
         pend_ff    <= frame.last;
      end else if (wr_busy_ff && wr_cnt_ff != 32'h0) begin
         wr_cnt_ff  <= wr_cnt_ff - 32'h1; // RL12
      end else begin
         wr_busy_ff <= 1'b0; // RL15
      end
   end

   // only bits 7:2 are stored; 1:0 are live
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         status_ff <= STATUS_PROT_RST;
      end else if (wr_done && !wr_nv_ff) begin
         status_ff <= pend_ff[7:2]; // RL13
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         nvcfg_ff <= NVCFG_RST;
      end else if (wr_done && wr_nv_ff) begin
         nvcfg_ff <= pend_ff; // RL12
      end
   end

   // volatile config: immediate, reserved bits keep their value
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         vcfg_ff <= VCFG_RST;
      end else if (do_vw) begin
         vcfg_ff <= (vcfg_ff & VCFG_RSVD_MASK) | (frame.last & ~VCFG_RSVD_MASK); // RL16
      end
   end

   ////////////////////////////////
   // core domain: write enable latch and error flags

   // write end first, then set, then clears
   wire logic nxt_wel = wr_done                   ? 1'b0 : // RL15
                        do_set                    ? 1'b1 : // RL4
                        (do_clr && !prot_err_ff)  ? 1'b0 : // RL5
                        (do_fclr && prot_err_ff)  ? 1'b0 : // RL6
                        sw_block                  ? 1'b0 : // RL14
                                                    wel_ff;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wel_ff <= 1'b0; // RL3
      end else begin
         wel_ff <= nxt_wel;
      end
   end

   // set beats clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         erase_err_ff <= 1'b0;
         prog_err_ff  <= 1'b0;
         prot_err_ff  <= 1'b0;
      end else begin
         erase_err_ff <= erase_fail_i | (erase_err_ff & ~do_fclr); // RL6
         prog_err_ff  <= program_fail_i | (prog_err_ff & ~do_fclr); // RL6
         prot_err_ff  <= protect_fail_i | sw_block | (prot_err_ff & ~do_fclr); // RL6 RL14
      end
   end

   ////////////////////////////////
   // core domain: read views

   wire logic busy_all = wr_busy_ff | array_busy_i; // RL15

   always_comb begin
      status_byte         = {status_ff, 2'b00};
      status_byte[SR_WEL]  = wel_ff;
      status_byte[SR_BUSY] = busy_all; // RL15
   end

   always_comb begin
      flag_byte                = 8'h00;
      flag_byte[FSR_READY]     = ~busy_all; // RL8
      flag_byte[FSR_ERASE_ERR] = erase_err_ff;
      flag_byte[FSR_PROG_ERR]  = prog_err_ff;
      flag_byte[FSR_PROT_ERR]  = prot_err_ff;
   end

   // reserved config fields always read back as ones
   assign core_view = '{octal:     octal_mode_i,
                        four_byte: four_byte_mode_i,
                        status:    status_byte,
                        flag:      flag_byte,
                        nvcfg:     nvcfg_ff | NVCFG_RSVD_MASK, // RL9
                        vcfg:      vcfg_ff | VCFG_RSVD_MASK}; // RL9

   assign wel_o         = wel_ff;
   assign busy_o        = busy_all;
   assign status_o      = status_byte;
   assign flag_status_o = flag_byte;
   assign nvcfg_o       = core_view.nvcfg;
   assign vcfg_o        = core_view.vcfg;

endmodule : flash_reg_cmd
`default_nettype wire

// ===== verif/flash_reg_cmd_monitor.sv
// port checker of the register command block
`timescale 1ns/1ps
`default_nettype none
module flash_reg_cmd_monitor
   import flash_reg_pkg::*;
#(
   parameter logic [7:0] NVCFG_RSVD_MASK = CFG_RSVD_MASK,
   parameter logic [7:0] VCFG_RSVD_MASK  = CFG_RSVD_MASK
) (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       chip_select_n_i,
   input wire logic       octal_mode_i,
   input wire logic       array_busy_i,
   input wire logic       program_fail_i,
   input wire logic       protect_fail_i,
   input wire logic [7:0] dq_o,
   input wire logic [7:0] dq_oe_o,
   input wire logic       wel_o,
   input wire logic       busy_o,
   input wire logic [7:0] status_o,
   input wire logic [7:0] flag_status_o,
   input wire logic [7:0] nvcfg_o,
   input wire logic [7:0] vcfg_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////
   // pins: output lanes only while selected, one lane in extended mode
   oe_idle_a: assert property (chip_select_n_i [*2] |-> dq_oe_o == 8'h00)
      else $error("oe while idle");
   oe_lanes_a: assert property (dq_oe_o != 8'h00 |-> dq_oe_o == (octal_mode_i ? 8'hff : 8'h02))
      else $error("oe lanes");
   ext_lane_a: assert property (dq_oe_o == 8'h02 |-> (dq_o & 8'hfd) == 8'h00)
      else $error("extended lanes");
   ////////////////////////////////
   // registers: live bits, flags and latch behaviour
   status_map_a: assert property (status_o[1:0] == {wel_o, busy_o})
      else $error("status live bits");
   flag_ready_a: assert property (flag_status_o[FSR_READY] == !busy_o)
      else $error("ready flag");
   busy_array_a: assert property (array_busy_i |-> busy_o)
      else $error("array busy");
   prot_set_a: assert property (protect_fail_i |=> flag_status_o[FSR_PROT_ERR])
      else $error("prot flag");
   prog_set_a: assert property (program_fail_i |=> flag_status_o[FSR_PROG_ERR])
      else $error("prog flag");
   wel_rise_a: assert property ($rose(wel_o) |-> $past(chip_select_n_i, 4))
      else $error("latch set early");
   prot_hold_a: assert property (wel_o && flag_status_o[FSR_PROT_ERR] |=>
      wel_o || !flag_status_o[FSR_PROT_ERR] || $fell(busy_o))
      else $error("latch dropped");
   busy_end_a: assert property ($fell(busy_o) && !$past(array_busy_i) |-> !wel_o)
      else $error("latch kept");
   stat_keep_a: assert property ($changed(status_o[7:2]) |-> $fell(busy_o))
      else $error("prot bits changed");
   cfg_rsvd_a: assert property ((vcfg_o & VCFG_RSVD_MASK) == VCFG_RSVD_MASK
      && (nvcfg_o & NVCFG_RSVD_MASK) == NVCFG_RSVD_MASK)
      else $error("reserved bits");
   // main scenarios
   c_wel: cover property ($rose(wel_o));
   c_busy: cover property ($fell(busy_o));
   c_read: cover property (dq_oe_o == 8'h02);
endmodule : flash_reg_cmd_monitor
bind flash_reg_cmd flash_reg_cmd_monitor #(
   .NVCFG_RSVD_MASK(NVCFG_RSVD_MASK), .VCFG_RSVD_MASK(VCFG_RSVD_MASK)) mon (
   .clk_i(clk_i), .reset_i(reset_i), .chip_select_n_i(chip_select_n_i),
   .octal_mode_i(octal_mode_i), .array_busy_i(array_busy_i), .program_fail_i(program_fail_i),
   .protect_fail_i(protect_fail_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .wel_o(wel_o),
   .busy_o(busy_o), .status_o(status_o), .flag_status_o(flag_status_o), .nvcfg_o(nvcfg_o),
   .vcfg_o(vcfg_o));
`default_nettype wire

// ===== verif/flash_host_model.sv
// host controller model: select, serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
   output logic            sclk_o,
   output logic            chip_select_n_o,
   output logic      [7:0] dq_o,
   input  wire logic       octal_i,
   input  wire logic [7:0] dq_i
);
   typedef logic [7:0] byte_q_type [$];
   // clock stands still low outside frames
   initial begin
      sclk_o = 1'b0;
      chip_select_n_o = 1'b1;
      dq_o = 8'h00;
   end
   // one rising edge, data set while the clock was low
   task automatic pulse();
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
   endtask : pulse
   // whole frame: tx bytes msb first, then nrd answer bytes
   task automatic frame(input byte_q_type tx, input int nrd, output byte_q_type rx);
      logic [7:0] b;
      rx = {};
      #2 chip_select_n_o = 1'b0;
      foreach (tx[k]) begin
         if (octal_i) begin
            dq_o = tx[k];
            pulse();
         end else begin
            for (int i = 7; i >= 0; i--) begin
               dq_o[0] = tx[k][i];
               pulse();
            end
         end
      end
      repeat (nrd) begin
         for (int i = 7; i >= 0; i--) begin
            #16 sclk_o = 1'b1;
            if (octal_i) b = dq_i;
            else b[i] = dq_i[1];
            #16 sclk_o = 1'b0;
            if (octal_i) break;
         end
         rx.push_back(b);
      end
      #16 chip_select_n_o = 1'b1;
      dq_o = ~dq_o; // no stale value
   endtask : frame
endmodule : flash_host_model
`default_nettype wire

// ===== verif/test_flash_reg_cmd.sv
// self-checking bench of the register command block
`timescale 1ns/1ps
`default_nettype none
module test_flash_reg_cmd;
   import flash_reg_pkg::*;
   localparam int unsigned WR_CYC = 400;
   localparam logic [7:0]  VMASK  = 8'hf0;
   typedef logic [7:0] byte_q_type [$];
   logic       clk_i, reset_i, sclk, cs_n, wp_n, octal, four, abusy, pfail, efail, xfail;
   logic       wel, busy;
   logic [7:0] host_dq, dq_in, dq_out, dq_oe, status, flag, nvcfg, vcfg;
   int         error_cnt, tests_run, n;
   byte_q_type rx;
   // wire level: device lanes win where enabled
   assign dq_in = (dq_out & dq_oe) | (host_dq & ~dq_oe);
   flash_reg_cmd #(.STATUS_WRITE_CYCLES(WR_CYC), .NVCFG_WRITE_CYCLES(WR_CYC),
      .VCFG_RSVD_MASK(VMASK)) DUT (
      .clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .chip_select_n_i(cs_n), .dq_i(dq_in),
      .dq_o(dq_out), .dq_oe_o(dq_oe), .write_protect_n_i(wp_n), .octal_mode_i(octal),
      .four_byte_mode_i(four), .array_busy_i(abusy), .program_fail_i(pfail),
      .erase_fail_i(efail), .protect_fail_i(xfail), .wel_o(wel), .busy_o(busy),
      .status_o(status), .flag_status_o(flag), .nvcfg_o(nvcfg), .vcfg_o(vcfg));
   flash_host_model host (.sclk_o(sclk), .chip_select_n_o(cs_n), .dq_o(host_dq),
      .octal_i(octal), .dq_i(dq_in));
   ////////////////////////////////
   // shared helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : tick
   // frame plus a gap for the core to act
   task automatic go(input byte_q_type tx, input int nrd);
      host.frame(tx, nrd, rx);
      tick(12);
   endtask : go
   // bounded wait on busy, counting cycles
   task automatic wait_busy(input logic lvl, input int lim);
      n = 0;
      while (busy !== lvl) begin
         if (n == lim) begin
            error_cnt++;
            $display("[ERR] busy expected %b seen %b", lvl, busy);
            give_verdict();
         end
         tick(1);
         n++;
      end
   endtask : wait_busy
   ////////////////////////////////
   // scenarios
   task automatic t_reset();
      check("wel", {7'h00, wel}, 8'h00);
      check("status", status, 8'h00);
      check("flag", flag, 8'h80);
      check("nvcfg", nvcfg, 8'hff);
      check("vcfg", vcfg, 8'hff);
   endtask : t_reset
   task automatic t_latch();
      go('{CMD_LATCH_SET}, 0);
      check("wel set", {7'h00, wel}, 8'h01);
      go('{CMD_LATCH_CLR}, 0);
      check("wel clr", {7'h00, wel}, 8'h00);
      go('{CMD_LATCH_SET, 8'h00}, 0);
      check("wel extra", {7'h00, wel}, 8'h00);
      octal = 1'b1;
      go('{CMD_LATCH_SET}, 0);
      check("wel octal", {7'h00, wel}, 8'h01);
      go('{CMD_LATCH_CLR}, 0);
      octal = 1'b0;
   endtask : t_latch
   task automatic t_nvcfg();
      go('{CMD_LATCH_SET}, 0);
      host.frame('{CMD_NVCFG_WR, 8'h00, 8'h00, 8'h00, 8'h5a}, 0, rx);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 2000);
      check("busy cycles", 8'((n >= WR_CYC - 2) && (n <= WR_CYC + 1)), 8'h01);
      check("nvcfg", nvcfg, 8'h5a);
      check("wel after", {7'h00, wel}, 8'h00);
   endtask : t_nvcfg
   task automatic t_status_wr();
      go('{CMD_LATCH_SET}, 0);
      host.frame('{CMD_STATUS_WR, 8'hff}, 0, rx);
      tick(10);
      check("busy", {7'h00, busy}, 8'h01);
      go('{CMD_STATUS_RD}, 2);
      check("sr read 0", rx[0], 8'h03);
      check("sr read 1", rx[1], 8'h03);
      wait_busy(1'b0, 1000);
      check("status", status, 8'hfc);
      wp_n = 1'b0;
      go('{CMD_LATCH_SET}, 0);
      go('{CMD_STATUS_WR, 8'h00}, 0);
      check("status locked", status, 8'hfc);
      check("flag locked", flag, 8'h82);
      check("wel locked", {7'h00, wel}, 8'h00);
      wp_n = 1'b1;
   endtask : t_status_wr
   task automatic t_flags();
      go('{CMD_LATCH_SET}, 0);
      go('{CMD_LATCH_CLR}, 0);
      check("wel pending", {7'h00, wel}, 8'h01);
      {pfail, efail, xfail} = 3'h7;
      tick(1);
      {pfail, efail, xfail} = 3'h0;
      tick(1);
      check("flag errs", flag, 8'hb2);
      go('{CMD_FLAG_CLR}, 0);
      check("flag clr", flag, 8'h80);
      check("wel clr", {7'h00, wel}, 8'h00);
      abusy = 1'b1;
      tick(12);
      go('{CMD_FLAG_RD}, 1);
      check("flag busy", rx[0], 8'h00);
      abusy = 1'b0;
   endtask : t_flags
   task automatic t_vcfg();
      four = 1'b1;
      go('{CMD_LATCH_SET}, 0);
      go('{CMD_VCFG_WR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05}, 0);
      check("vcfg", vcfg, 8'hf5);
      go('{CMD_VCFG_RD, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
      check("vcfg rd 0", rx[0], 8'hf5);
      check("vcfg rd 1", rx[1], 8'hf5);
      go('{CMD_VCFG_WR, 8'h00, 8'h00, 8'h00, 8'h0a}, 0);
      check("vcfg short", vcfg, 8'hf5);
      go('{CMD_LATCH_CLR}, 0);
      go('{CMD_VCFG_WR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a}, 0);
      check("vcfg no wel", vcfg, 8'hf5);
      four = 1'b0;
   endtask : t_vcfg
   ////////////////////////////////
   // core clock and main sequence
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      {reset_i, wp_n, octal, four, abusy, pfail, efail, xfail} = 8'hc0;
      error_cnt = 0;
      tests_run = 0;
      repeat (6) @(posedge clk_i);
      #1 reset_i = 1'b0;
      tick(6);
      t_reset();
      t_latch();
      t_nvcfg();
      t_status_wr();
      t_flags();
      t_vcfg();
      give_verdict();
   end
endmodule : test_flash_reg_cmd
`default_nettype wire
